// >>> phy_event_interrupt_unit.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "phy_irq_cfg.svh"

module phy_event_interrupt_unit
    import phy_irq_pkg::*;
(
    input  wire logic       SYS_CLK_I,   // System clock, 50 MHz
    input  wire logic       RST_I,       // Async reset, active high
    input  wire logic       PSEL_I,      // APB select
    input  wire logic       PENABLE_I,   // APB access phase
    input  wire logic       PWRITE_I,    // APB direction, 1 = write
    input  wire apb_addr_t  PADDR_I,     // APB byte address
    input  wire apb_data_t  PWDATA_I,    // APB write data
    input  wire logic [3:0] PSTRB_I,     // APB byte lane strobes
    input  wire event_vec_s EVENTS_I,    // Event flags from detectors
    output apb_data_t       PRDATA_O,    // APB read data
    output logic            PREADY_O,    // APB ready
    output logic            PSLVERR_O,   // APB error, unmapped address
    output logic            INT_O        // Interrupt pin to host
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions
    ////////////////////////////////////////////////////////////////////////

    // Pure helpers; nothing kept between calls
    // Byte address of a register index
    function automatic apb_addr_t reg_addr(input logic [9:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // Byte-lane merge of a write into a 16-bit register
    function automatic reg16_t lane_merge(input reg16_t     old_val,
                                          input apb_data_t  wdata,
                                          input logic [3:0] strb,
                                          input reg16_t     mask);
        reg16_t merged;
        merged = old_val;
        if (strb[0]) begin
            merged[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            merged[15:8] = wdata[15:8];
        end
        // Lanes 2 and 3 hold no register bits
        lane_merge = merged & mask;
    endfunction

    // Place each event flag on its register bit
    function automatic reg16_t event_bits(input event_vec_s ev);
        reg16_t v;
        v = 16'h0000;
        // Positions 9 and 7 are never written
        // negotiation fault
        v[`BIT_NEG_FAULT] = ev.negotiation_fault;
        v[`BIT_RATE_CHANGE] = ev.rate_change;
        v[`BIT_DUPLEX_CHANGE] = ev.duplex_change;
        v[`BIT_PAGE_RX] = ev.page_received;
        v[`BIT_NEG_DONE] = ev.negotiation_done;
        v[`BIT_LINK_CHANGE] = ev.link_change;
        v[`BIT_FALSE_CARRIER] = ev.false_carrier;
        v[`BIT_CROSSOVER] = ev.crossover_change;
        v[`BIT_DOWNSHIFT] = ev.downshift_event;
        v[`BIT_SLEEP_CHANGE] = ev.sleep_change;
        v[`BIT_WAKE_PACKET] = ev.wake_packet;
        v[`BIT_MAC_IF_ERROR] = ev.mac_if_error;
        v[`BIT_POLARITY_FLIP] = ev.polarity_flip;
        v[`BIT_JABBER] = ev.jabber;
        event_bits = v & `IRQ_EVENT_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////

    // Bus phase and held request
    apb_state_e state_reg;
    apb_state_e state_next;
    apb_req_s   req;

    // Software-visible registers
    reg16_t     enable_reg;
    reg16_t     enable_next;
    reg16_t     config_reg;
    reg16_t     config_next;

    // Latch banks and their set and clear vectors
    reg16_t     status_q;
    reg16_t     armed_q;
    reg16_t     event_vec;
    reg16_t     armed_set;
    reg16_t     ack_mask_reg;
    reg16_t     ack_clear;

    // Bus answer and interrupt request
    apb_data_t  rdata_reg;
    logic       slverr_reg;
    logic       int_pin_reg;
    reg16_t     irq_request;
    logic       irq_active;

    // Phase qualifiers and address decode
    logic       setup_cycle;
    logic       xfer_done;
    logic       wr_done;
    logic       rd_done;
    logic       hit_enable;
    logic       hit_status;
    logic       hit_config;
    logic       hit_any;

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    ////////////////////////////////////////////////////////////////////////

    // Transfer timing as the master sees it
    //   setup edge:   decode, error flag and read data captured
    //   access cycle: ready high, no wait state inserted
    //   access edge:  write lands, reported status bits clear
    // Read data holds until the next setup edge
    // Write data lanes 2 and 3 are ignored

    // Bundle the held request fields
    assign req = '{paddr:  PADDR_I,
                   pwrite: PWRITE_I,
                   pwdata: PWDATA_I,
                   pstrb:  PSTRB_I};

    // Address decode
    assign hit_enable = (req.paddr == reg_addr(`IRQ_ENABLE_IDX));
    assign hit_status = (req.paddr == reg_addr(`IRQ_STATUS_IDX));
    assign hit_config = (req.paddr == reg_addr(`IRQ_CONFIG_IDX));
    assign hit_any    = hit_enable | hit_status | hit_config;

    // Phase qualifiers; access completes on its first edge
    assign setup_cycle = PSEL_I & ~PENABLE_I;
    assign xfer_done   = (state_reg == ST_ACCESS) & PSEL_I & PENABLE_I;
    assign wr_done     = xfer_done & req.pwrite & ~slverr_reg;
    assign rd_done     = xfer_done & ~req.pwrite & ~slverr_reg;

    // Phase tracking
    // Setup is only taken from idle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (setup_cycle) begin
                    state_next = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (xfer_done) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Read data and error are captured in setup so the bus sees flops
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_reg  <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && setup_cycle) begin
            slverr_reg <= ~hit_any;
            // Writes and unmapped reads return zero
            if (req.pwrite || !hit_any) begin
                rdata_reg <= 32'h0000_0000;
            end else if (hit_enable) begin
                rdata_reg <= {16'h0000, enable_reg};
            end else if (hit_status) begin
                // Same value as the clear snapshot below
                rdata_reg <= {16'h0000, status_q};
            end else begin
                rdata_reg <= {16'h0000, config_reg};
            end
        end
    end

    // Snapshot of the bits a status read reports
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_mask_reg <= 16'h0000;
        end else if (state_reg == ST_IDLE && setup_cycle) begin
            ack_mask_reg <= (hit_status && !req.pwrite) ? status_q : 16'h0000;
        end
    end

    // Only the reported bits are cleared; later arrivals stay pending
    // clear on read
    assign ack_clear = rd_done ? ack_mask_reg : 16'h0000;

    assign PREADY_O  = (state_reg == ST_ACCESS);
    assign PSLVERR_O = (state_reg == ST_ACCESS) & slverr_reg;
    assign PRDATA_O  = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    ////////////////////////////////////////////////////////////////////////

    // Writes land only at a clean access edge; an error stops them
    // Reserved and unimplemented bits are masked in the merge
    // Status register has no write path: writes are dropped silently

    // Enable register write; reserved bits forced to zero
    always_comb begin
        enable_next = enable_reg;
        if (wr_done && hit_enable) begin
            enable_next = lane_merge(enable_reg, req.pwdata, req.pstrb,
                                     `IRQ_EVENT_MASK);
        end
    end

    // Configuration write; only the polarity bit is implemented
    always_comb begin
        config_next = config_reg;
        if (wr_done && hit_config) begin
            config_next = lane_merge(config_reg, req.pwdata, req.pstrb,
                                     `IRQ_CONFIG_MASK);
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            enable_reg <= `IRQ_ENABLE_RST;
        end else begin
            enable_reg <= enable_next;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            config_reg <= `IRQ_CONFIG_RST;
        end else begin
            config_reg <= config_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event latching
    ////////////////////////////////////////////////////////////////////////

    // Two banks share the read clear
    //   status bank: every event, for software
    //   armed bank:  only events that met their enable, for the pin
    // Both let a set win over a clear in the same cycle
    // Limitation: an event repeated before its read is counted once

    // Detectors share this clock, so no synchroniser is needed
    assign event_vec = event_bits(EVENTS_I);

    event_latch_bank u_status_bank (
        .clk_i (SYS_CLK_I),
        .rst_i (RST_I),
        .set_i (event_vec),
        .clr_i (ack_clear),
        .q_o   (status_q)
    );

    // Events that arrived while enabled; enabling later raises nothing
    // arm only when enabled
    assign armed_set = event_vec & enable_reg;

    event_latch_bank u_armed_bank (
        .clk_i (SYS_CLK_I),
        .rst_i (RST_I),
        .set_i (armed_set),
        .clr_i (ack_clear),
        .q_o   (armed_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin
    ////////////////////////////////////////////////////////////////////////

    // Per-event request; disabling an enable withdraws it at once
    // A bit whose event came while disabled never requests
    // pending and enabled
    assign irq_request = armed_q & status_q & enable_reg;
    assign irq_active  = |irq_request;

    // Pin follows the event by two edges: latch, then this flop
    // Changing polarity with a request standing moves the pin too

    // Registered pin so polarity changes never glitch the host line
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            int_pin_reg <= `INT_PIN_RST;
        end else begin
            int_pin_reg <= config_reg[`BIT_PIN_ACTIVE_LOW] ? ~irq_active
                                                           : irq_active;
        end
    end

    assign INT_O = int_pin_reg;

endmodule

// >>> phy_irq_cfg.svh
`ifndef PHY_IRQ_CFG_SVH
`define PHY_IRQ_CFG_SVH

// Register indices; byte address is four times the index
`define IRQ_ENABLE_IDX    10'h012
`define IRQ_STATUS_IDX    10'h013
`define IRQ_CONFIG_IDX    10'h014

// Event bit positions, shared by enable and status
`define BIT_NEG_FAULT     15
`define BIT_RATE_CHANGE   14
`define BIT_DUPLEX_CHANGE 13
`define BIT_PAGE_RX       12
`define BIT_NEG_DONE      11
`define BIT_LINK_CHANGE   10
`define BIT_FALSE_CARRIER 8
`define BIT_CROSSOVER     6
`define BIT_DOWNSHIFT     5
`define BIT_SLEEP_CHANGE  4
`define BIT_WAKE_PACKET   3
`define BIT_MAC_IF_ERROR  2
`define BIT_POLARITY_FLIP 1
`define BIT_JABBER        0

// Configuration register: pin polarity select
`define BIT_PIN_ACTIVE_LOW 13

// Reset values and implemented-bit masks
`define IRQ_ENABLE_RST    16'h0000
`define IRQ_STATUS_RST    16'h0000
`define IRQ_CONFIG_RST    16'h2000
`define IRQ_EVENT_MASK    16'hfd7f
`define IRQ_CONFIG_MASK   16'h2000
`define INT_PIN_RST       1'h1

`endif

// >>> phy_irq_pkg.sv
package phy_irq_pkg;

    // APB address and data widths
    typedef logic [11:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;
    typedef logic [15:0] reg16_t;

    // One flag per event source, same-clock pulses or levels
    typedef struct packed {
        logic negotiation_fault;
        logic rate_change;
        logic duplex_change;
        logic page_received;
        logic negotiation_done;
        logic link_change;
        logic false_carrier;
        logic crossover_change;
        logic downshift_event;
        logic sleep_change;
        logic wake_packet;
        logic mac_if_error;
        logic polarity_flip;
        logic jabber;
    } event_vec_s;

    // Request fields held by the master through a transfer
    typedef struct packed {
        apb_addr_t   paddr;
        logic        pwrite;
        apb_data_t   pwdata;
        logic [3:0]  pstrb;
    } apb_req_s;

    // Slave phase tracking
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } apb_state_e;

endpackage

// >>> event_latch_bank.sv
`timescale 1ns/1ps
`include "phy_irq_cfg.svh"

module event_latch_bank
    import phy_irq_pkg::*;
(
    input  wire logic   clk_i,   // System clock
    input  wire logic   rst_i,   // Async reset, active high
    input  wire reg16_t set_i,   // Bits to latch high
    input  wire reg16_t clr_i,   // Bits acknowledged by a read
    output reg16_t      q_o      // Latched bits
);

    reg16_t latch_reg;
    reg16_t latch_next;

    // Set wins over clear so an event in the clearing cycle survives
    always_comb begin
        latch_next = ((latch_reg & ~clr_i) | set_i) & `IRQ_EVENT_MASK;
    end

    // Latched-high storage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_reg <= `IRQ_STATUS_RST;
        end else begin
            latch_reg <= latch_next;
        end
    end

    assign q_o = latch_reg;

endmodule

// >>> phy_irq_asserts.sv
`timescale 1ns/1ps
module phy_irq_asserts
    import phy_irq_pkg::*;
(
    input wire logic       SYS_CLK_I,  // Clock
    input wire logic       RST_I,      // Reset
    input wire logic       PSEL_I,     // Select
    input wire logic       PENABLE_I,  // Access phase
    input wire logic       PWRITE_I,   // Direction
    input wire apb_addr_t  PADDR_I,    // Address
    input wire apb_data_t  PWDATA_I,   // Write data
    input wire logic [3:0] PSTRB_I,    // Strobes
    input wire event_vec_s EVENTS_I,   // Event flags
    input wire apb_data_t  PRDATA_O,   // Read data
    input wire logic       PREADY_O,   // Ready
    input wire logic       PSLVERR_O,  // Error
    input wire logic       INT_O       // Interrupt pin
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    // Zero wait states: ready only right after a setup
    ready_phase_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I && $past(PSEL_I && !PENABLE_I))
        else $error("ready outside the access cycle");
    setup_answer_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("setup not answered next cycle");
    // Upper half and bits 9, 7 never read as one
    rsvd_zero_a: assert property (PREADY_O |-> (PRDATA_O & 32'hffff0280) == 32'h0)
        else $error("reserved read data bit set");
    unmapped_err_a: assert property (PREADY_O |-> PSLVERR_O == !(PADDR_I inside {12'h048, 12'h04c, 12'h050}))
        else $error("error flag disagrees with address map");
    err_data_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
        else $error("error without ready or with data");
    // Read data only moves at a setup edge
    rdata_hold_a: assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O))
        else $error("read data moved outside setup");
    // Pin moves only as a result of an event or an access
    int_cause_a: assert property ($changed(INT_O) |->
        $past(|EVENTS_I, 2) || $past(PREADY_O, 2) || $past(PREADY_O))
        else $error("pin changed without cause");
    reset_vals_a: assert property ($fell(RST_I) |-> INT_O && PRDATA_O == 32'h0 && !PREADY_O)
        else $error("outputs not at reset values");
endmodule

bind phy_event_interrupt_unit phy_irq_asserts u_chk (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .EVENTS_I(EVENTS_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .INT_O(INT_O)
);

// >>> host_apb_model.sv
`timescale 1ns/1ps
module host_apb_model
    import phy_irq_pkg::*;
(
    input  wire logic       clk_i,      // System clock
    input  wire apb_data_t  prdata_i,   // Read data
    input  wire logic       pready_i,   // Ready
    input  wire logic       pslverr_i,  // Error
    output logic            psel_o,     // Select
    output logic            penable_o,  // Access phase
    output logic            pwrite_o,   // Direction
    output apb_addr_t       paddr_o,    // Address
    output apb_data_t       pwdata_o,   // Write data
    output logic [3:0]      pstrb_o     // Strobes
);
    apb_data_t rdata;  // Data of last transfer
    logic      err;    // Error of last transfer

    // Idle bus from time zero
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 12'h0;
        pwdata_o  = 32'h0;
        pstrb_o   = 4'h0;
    end

    // One transfer; answer taken at the edge that samples ready high
    task automatic xfer(input logic wr, input apb_addr_t a, input apb_data_t d, input logic [3:0] s);
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= wr;
        paddr_o   <= a;
        pwdata_o  <= d;
        pstrb_o   <= s;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) begin
            @(posedge clk_i);
        end
        rdata = prdata_i;
        err   = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        // Released lines show garbage, not the old request
        paddr_o   <= ~a;
        pwdata_o  <= ~d;
    endtask
endmodule

// >>> test_phy_event_interrupt_unit.sv
`timescale 1ns/1ps
module test_phy_event_interrupt_unit
    import phy_irq_pkg::*;
;
    localparam apb_addr_t EN_A = apb_addr_t'(4 * 'h12);
    localparam apb_addr_t ST_A = apb_addr_t'(4 * 'h13);
    localparam apb_addr_t CF_A = apb_addr_t'(4 * 'h14);
    localparam int        POS[14] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 11, 12, 13, 14, 15};
    logic       clk = 1'b0;  // System clock
    logic       rst = 1'b1;  // Reset
    logic       psel, penable, pwrite, pready, pslverr, int_pin;
    apb_addr_t  paddr;
    apb_data_t  pwdata, prdata;
    logic [3:0] pstrb;
    event_vec_s ev = '0;     // Event flags
    int         err_count = 0;
    int         num_checks = 0;
    int         cycles = 0;

    phy_event_interrupt_unit dut (
        .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .EVENTS_I(ev),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .INT_O(int_pin));
    host_apb_model host (
        .clk_i(clk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));

    // 50 MHz clock and a hang limit well above the run length
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            complete_run;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input apb_addr_t a);
        host.xfer(1'b0, a, 32'h0, 4'h0);
    endtask
    task automatic wr(input apb_addr_t a, input apb_data_t d);
        host.xfer(1'b1, a, d, 4'h3);
    endtask
    // One-cycle event flag; pin follows two edges later
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= event_vec_s'(14'h1 << i);
        @(posedge clk);
        ev <= '0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pin(input logic exp, input string nm);
        chk(nm, {31'h0, int_pin}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(EN_A);
        chk("enable reset", host.rdata, 32'h0);
        rd(ST_A);
        chk("status reset", host.rdata, 32'h0);
        rd(CF_A);
        chk("config reset", host.rdata, 32'h2000);
        pin(1'b1, "pin idle");
    endtask
    // Reserved bits stay zero; lanes written on their own
    task automatic t_enable;
        wr(EN_A, 32'hffff_ffff);
        rd(EN_A);
        chk("enable all", host.rdata, 32'hfd7f);
        host.xfer(1'b1, EN_A, 32'h0, 4'h1);
        rd(EN_A);
        chk("enable lane0", host.rdata, 32'hfd00);
        host.xfer(1'b1, EN_A, 32'hffff_ffff, 4'h1);
        host.xfer(1'b1, EN_A, 32'h0, 4'hc);
        host.xfer(1'b1, EN_A, 32'h0, 4'h2);
        rd(EN_A);
        chk("enable lane1", host.rdata, 32'h007f);
        wr(EN_A, 32'h0);
    endtask
    task automatic t_map;
        for (int i = 0; i < 14; i++) begin
            pulse(i);
            settle;
            pin(1'b1, "pin masked");
            rd(ST_A);
            chk("status bit", host.rdata, 32'h1 << POS[i]);
            rd(ST_A);
            chk("status cleared", host.rdata, 32'h0);
        end
    endtask
    task automatic t_irq;
        wr(EN_A, 32'h0400);
        pulse(8);
        settle;
        pin(1'b0, "pin raised");
        wr(EN_A, 32'h0);
        settle;
        pin(1'b1, "pin disabled");
        wr(EN_A, 32'h0400);
        settle;
        pin(1'b0, "pin re-enabled");
        repeat (20) @(posedge clk);
        rd(ST_A);
        chk("status held", host.rdata, 32'h0400);
        settle;
        pin(1'b1, "pin released");
        // Enabling after the event must not raise the pin
        wr(EN_A, 32'h0);
        pulse(8);
        wr(EN_A, 32'h0400);
        settle;
        pin(1'b1, "pin late enable");
        rd(ST_A);
        chk("status late", host.rdata, 32'h0400);
        wr(CF_A, 32'h0);
        settle;
        pin(1'b0, "pin high idle");
        pulse(8);
        settle;
        pin(1'b1, "pin high active");
        rd(ST_A);
        wr(CF_A, 32'hffff);
        settle;
        pin(1'b1, "pin low idle");
        rd(CF_A);
        chk("config mask", host.rdata, 32'h2000);
    endtask
    task automatic t_unmapped;
        rd(12'h100);
        chk("unmapped err", {31'h0, host.err}, 32'h1);
        chk("unmapped data", host.rdata, 32'h0);
        wr(12'h100, 32'hffff);
        chk("unmapped wr err", {31'h0, host.err}, 32'h1);
        wr(ST_A, 32'hffff);
        chk("status write err", {31'h0, host.err}, 32'h0);
        rd(ST_A);
        chk("status write", host.rdata, 32'h0);
    endtask
    // Event sampled at the clearing edge survives the read
    task automatic t_race;
        fork
            rd(ST_A);
            begin
                repeat (2) @(posedge clk);
                ev <= event_vec_s'(14'h1);
                @(posedge clk);
                ev <= '0;
            end
        join
        chk("race read", host.rdata, 32'h0);
        rd(ST_A);
        chk("race kept", host.rdata, 32'h0001);
        rd(ST_A);
        chk("race cleared", host.rdata, 32'h0);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_enable;
        t_map;
        t_irq;
        t_unmapped;
        t_race;
        complete_run;
    end
endmodule
